// ---- hdl/rbrm_top.sv ----
// receive buffer ring manager: local receive dma page linking, header and recovery
`timescale 1ns/1ns
`default_nettype none

module rbrm_top (
  // clock, reset, enable
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // receive byte stream from the front end
  input wire logic frm_start_i,
  input wire logic frm_byte_valid_i,
  input wire logic [7:0] frm_byte_i,
  input wire logic frm_end_i,
  input wire rbrm_pkg::rbrm_frame_end_type frm_verdict_i,
  // local buffer memory write port
  output rbrm_pkg::rbrm_mem_wr_type mem_wr_o,
  // ring status
  output logic ring_overwrite_warning_o
);

  // ----------------------------------------------------------------
  // registers and working state
  // ----------------------------------------------------------------
  logic [7:0] command_r;
  logic [7:0] ring_first_page_r;
  logic [7:0] ring_limit_page_r;
  logic [7:0] read_pointer_page_r;
  logic [7:0] write_pointer_page_r;
  logic [7:0] receive_configuration_r;
  logic [7:0] transmit_configuration_r;
  logic [7:0] missed_tally_r;
  logic ring_overwrite_warning_r;
  logic ring_full_r;
  rbrm_pkg::rbrm_state_type state_r;
  logic [7:0] cur_page_r;
  logic [7:0] offset_r;
  logic page_full_r;
  logic [15:0] byte_count_r;
  logic [7:0] next_frame_page_r;
  logic [7:0] frame_status_r;
  logic [1:0] hdr_index_r;

  logic halted;
  logic rx_active;
  logic [7:0] link_page;
  logic link_hits_read;
  logic start_ok;
  logic start_full;
  logic link_needed;
  logic link_abort;
  logic frame_reject;
  logic abort_event;
  logic wr_read_ptr;
  logic [7:0] store_page;
  logic [7:0] hdr_byte;
  logic [7:0] ring_state;

  // ----------------------------------------------------------------
  // page linking and receive gating
  // ----------------------------------------------------------------
  // one link calculator serves both reception and the header pointer
  rbrm_page_link u_link (
    .page_i(cur_page_r),
    .first_page_i(ring_first_page_r),
    .limit_page_i(ring_limit_page_r),
    .read_page_i(read_pointer_page_r),
    .next_page_o(link_page),
    .hits_read_o(link_hits_read)
  );

  // receive needs start, no halt and both loopback bits clear
  assign halted = command_r[rbrm_pkg::CMD_HALT_BIT];
  assign rx_active = !halted && command_r[rbrm_pkg::CMD_START_BIT] &&
    !transmit_configuration_r[rbrm_pkg::TXC_LOOP_LO_BIT] &&
    !transmit_configuration_r[rbrm_pkg::TXC_LOOP_HI_BIT];
  assign start_ok = (state_r == rbrm_pkg::ST_IDLE) && frm_start_i && rx_active;
  assign start_full = start_ok && ring_full_r;
  assign link_needed = (state_r == rbrm_pkg::ST_STORE) && frm_byte_valid_i && page_full_r;
  assign link_abort = link_needed && link_hits_read;
  assign abort_event = start_full || link_abort;
  assign frame_reject = (frm_verdict_i.runt && !receive_configuration_r[rbrm_pkg::RXC_ACCEPT_RUNT_BIT]) ||
    ((frm_verdict_i.crc_err || frm_verdict_i.align_err) &&
     !receive_configuration_r[rbrm_pkg::RXC_ACCEPT_ERR_BIT]);
  assign wr_read_ptr = reg_wr_i && (reg_addr_i == rbrm_pkg::REG_READ_PTR);
  // a freshly linked page takes the byte that overflowed the old one
  assign store_page = page_full_r ? link_page : cur_page_r;

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  // plain storage; the write pointer is owned by the dma process
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      command_r <= rbrm_pkg::COMMAND_RESET;
      ring_first_page_r <= rbrm_pkg::PAGE_RESET;
      ring_limit_page_r <= rbrm_pkg::LIMIT_RESET;
      read_pointer_page_r <= rbrm_pkg::PAGE_RESET;
      receive_configuration_r <= rbrm_pkg::BYTE_ZERO;
      transmit_configuration_r <= rbrm_pkg::BYTE_ZERO;
    end else if (ce_i && reg_wr_i) begin
      if (reg_addr_i == rbrm_pkg::REG_COMMAND) begin
        command_r <= reg_wdata_i;
      end else if (reg_addr_i == rbrm_pkg::REG_RING_FIRST) begin
        ring_first_page_r <= reg_wdata_i;
      end else if (reg_addr_i == rbrm_pkg::REG_RING_LIMIT) begin
        ring_limit_page_r <= reg_wdata_i;
      end else if (reg_addr_i == rbrm_pkg::REG_READ_PTR) begin
        read_pointer_page_r <= reg_wdata_i;
      end else if (reg_addr_i == rbrm_pkg::REG_RX_CONFIG) begin
        receive_configuration_r <= reg_wdata_i;
      end else if (reg_addr_i == rbrm_pkg::REG_TX_CONFIG) begin
        transmit_configuration_r <= reg_wdata_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // overwrite warning and missed tally
  // ----------------------------------------------------------------
  // write one to clear; a new overflow in the same cycle wins
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ring_overwrite_warning_r <= 1'b0;
    end else if (ce_i) begin
      if (abort_event) begin
        ring_overwrite_warning_r <= 1'b1;
      end else if (reg_wr_i && (reg_addr_i == rbrm_pkg::REG_INT_STATUS) &&
                   reg_wdata_i[rbrm_pkg::INT_OVERWRITE_BIT]) begin
        ring_overwrite_warning_r <= 1'b0;
      end
    end
  end

  // saturates rather than wraps so a flood stays visible
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      missed_tally_r <= rbrm_pkg::BYTE_ZERO;
    end else if (ce_i && !halted && abort_event && (missed_tally_r != rbrm_pkg::MISSED_MAX)) begin
      missed_tally_r <= missed_tally_r + rbrm_pkg::MISSED_ONE;
    end
  end

  // ----------------------------------------------------------------
  // receive dma sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state_r <= rbrm_pkg::ST_IDLE;
      cur_page_r <= rbrm_pkg::PAGE_RESET;
      offset_r <= rbrm_pkg::BYTE_ZERO;
      page_full_r <= 1'b0;
      byte_count_r <= 16'h0000;
      next_frame_page_r <= rbrm_pkg::PAGE_RESET;
      frame_status_r <= rbrm_pkg::BYTE_ZERO;
      hdr_index_r <= rbrm_pkg::HDR_STATUS;
      write_pointer_page_r <= rbrm_pkg::PAGE_RESET;
      ring_full_r <= 1'b0;
    end else if (ce_i) begin
      // software may reposition the pointers; a read pointer write clears ring full
      if (reg_wr_i && (reg_addr_i == rbrm_pkg::REG_WRITE_PTR)) begin
        write_pointer_page_r <= reg_wdata_i;
      end
      if (wr_read_ptr) begin
        ring_full_r <= 1'b0;
      end
      case (state_r)
        rbrm_pkg::ST_IDLE: begin
          if (start_full) begin
            state_r <= rbrm_pkg::ST_DROP;
          end else if (start_ok) begin
            state_r <= rbrm_pkg::ST_STORE;
            cur_page_r <= write_pointer_page_r;
            offset_r <= rbrm_pkg::HEADER_BYTES;
            page_full_r <= 1'b0;
            byte_count_r <= 16'h0000;
          end
        end
        rbrm_pkg::ST_STORE: begin
          if (frm_end_i) begin
            if (frame_reject) begin
              state_r <= rbrm_pkg::ST_IDLE;
            end else begin
              next_frame_page_r <= link_page;
              frame_status_r <= frm_verdict_i.status;
              hdr_index_r <= rbrm_pkg::HDR_STATUS;
              state_r <= rbrm_pkg::ST_HEADER;
            end
          end else if (link_abort) begin
            state_r <= rbrm_pkg::ST_DROP;
          end else if (frm_byte_valid_i) begin
            // every byte, the trailing crc included, lands in the ring
            if (page_full_r) begin
              cur_page_r <= link_page;
            end
            page_full_r <= (offset_r == rbrm_pkg::PAGE_LAST_OFFSET);
            offset_r <= offset_r + 8'h01;
            byte_count_r <= byte_count_r + rbrm_pkg::COUNT_ONE;
          end
        end
        rbrm_pkg::ST_DROP: begin
          if (frm_end_i) begin
            state_r <= rbrm_pkg::ST_IDLE;
          end
        end
        rbrm_pkg::ST_HEADER: begin
          hdr_index_r <= hdr_index_r + 2'h1;
          if (hdr_index_r == rbrm_pkg::HDR_LAST_INDEX) begin
            // remainder of the last page is abandoned
            write_pointer_page_r <= next_frame_page_r;
            ring_full_r <= (next_frame_page_r == read_pointer_page_r) && !wr_read_ptr;
            state_r <= rbrm_pkg::ST_IDLE;
          end
        end
        default: begin
          state_r <= rbrm_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // buffer memory writes
  // ----------------------------------------------------------------
  always_comb begin
    if (hdr_index_r == rbrm_pkg::HDR_STATUS) begin
      hdr_byte = frame_status_r;
    end else if (hdr_index_r == rbrm_pkg::HDR_NEXT_PAGE) begin
      hdr_byte = next_frame_page_r;
    end else if (hdr_index_r == rbrm_pkg::HDR_COUNT_LO) begin
      hdr_byte = byte_count_r[7:0];
    end else begin
      hdr_byte = byte_count_r[15:8];
    end
  end

  // the header rewinds to the write pointer page, offsets zero to three
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      mem_wr_o <= '0;
    end else if (ce_i) begin
      if (state_r == rbrm_pkg::ST_HEADER) begin
        mem_wr_o.we <= 1'b1;
        mem_wr_o.addr <= {write_pointer_page_r, 6'h00, hdr_index_r};
        mem_wr_o.data <= hdr_byte;
      end else if ((state_r == rbrm_pkg::ST_STORE) && frm_byte_valid_i && !frm_end_i && !link_abort) begin
        mem_wr_o.we <= 1'b1;
        mem_wr_o.addr <= {store_page, offset_r};
        mem_wr_o.data <= frm_byte_i;
      end else begin
        mem_wr_o.we <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // read data and status output
  // ----------------------------------------------------------------
  assign ring_state = {5'h00, (state_r != rbrm_pkg::ST_IDLE),
    (write_pointer_page_r == read_pointer_page_r) && !ring_full_r, ring_full_r};

  // read data stands only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= rbrm_pkg::BYTE_ZERO;
      ring_overwrite_warning_o <= 1'b0;
    end else if (ce_i) begin
      ring_overwrite_warning_o <= ring_overwrite_warning_r;
      if (!reg_rd_i) begin
        reg_rdata_o <= rbrm_pkg::BYTE_ZERO;
      end else if (reg_addr_i == rbrm_pkg::REG_COMMAND) begin
        reg_rdata_o <= command_r;
      end else if (reg_addr_i == rbrm_pkg::REG_RING_FIRST) begin
        reg_rdata_o <= ring_first_page_r;
      end else if (reg_addr_i == rbrm_pkg::REG_RING_LIMIT) begin
        reg_rdata_o <= ring_limit_page_r;
      end else if (reg_addr_i == rbrm_pkg::REG_READ_PTR) begin
        reg_rdata_o <= read_pointer_page_r;
      end else if (reg_addr_i == rbrm_pkg::REG_WRITE_PTR) begin
        reg_rdata_o <= write_pointer_page_r;
      end else if (reg_addr_i == rbrm_pkg::REG_INT_STATUS) begin
        reg_rdata_o <= {3'h0, ring_overwrite_warning_r, 4'h0};
      end else if (reg_addr_i == rbrm_pkg::REG_RX_CONFIG) begin
        reg_rdata_o <= receive_configuration_r;
      end else if (reg_addr_i == rbrm_pkg::REG_TX_CONFIG) begin
        reg_rdata_o <= transmit_configuration_r;
      end else if (reg_addr_i == rbrm_pkg::REG_MISSED) begin
        reg_rdata_o <= missed_tally_r;
      end else if (reg_addr_i == rbrm_pkg::REG_RING_STATE) begin
        reg_rdata_o <= ring_state;
      end else begin
        reg_rdata_o <= rbrm_pkg::BYTE_ZERO;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_link_wrap_first: assert property (
    (ce_i && link_needed && !link_abort && !frm_end_i && (cur_page_r + 8'h01 == ring_limit_page_r))
    |=> (mem_wr_o.we && (mem_wr_o.addr[15:8] == ring_first_page_r)))
    else $error("link at limit page did not wrap to first page");

  a_link_abort_read: assert property (
    (ce_i && link_abort && !frm_end_i) |=> (!mem_wr_o.we && (state_r == rbrm_pkg::ST_DROP)))
    else $error("link onto read pointer page was not aborted");

  a_page_consecutive: assert property (
    (ce_i && link_needed && !link_abort && !frm_end_i) |=> (cur_page_r == $past(link_page)))
    else $error("linked page is not the next ring page");

  a_overflow_warning: assert property (
    (ce_i && abort_event) |=> ring_overwrite_warning_r ##1 ring_overwrite_warning_o)
    else $error("overflow abort did not raise the overwrite warning");

  a_halt_tally_frozen: assert property (
    (ce_i && halted) |=> (missed_tally_r == $past(missed_tally_r)))
    else $error("missed tally changed while halted");

  a_loopback_no_rx: assert property (
    (ce_i && (state_r == rbrm_pkg::ST_IDLE) && !rx_active) |=> (state_r == rbrm_pkg::ST_IDLE))
    else $error("frame accepted while receive dma inactive");

  a_header_at_wp: assert property (
    (ce_i && (state_r == rbrm_pkg::ST_HEADER) && (hdr_index_r == rbrm_pkg::HDR_STATUS))
    |=> (mem_wr_o.addr == {$past(write_pointer_page_r), rbrm_pkg::BYTE_ZERO}))
    else $error("header not written at write pointer page");

  a_reject_restores: assert property (
    (ce_i && (state_r == rbrm_pkg::ST_STORE) && frm_end_i && frame_reject && !reg_wr_i)
    |=> ((state_r == rbrm_pkg::ST_IDLE) && $stable(write_pointer_page_r)))
    else $error("rejected frame moved the write pointer");

  a_first_offset: assert property (
    (ce_i && start_ok && !start_full) |=> (offset_r == rbrm_pkg::HEADER_BYTES))
    else $error("frame did not start four bytes into the page");

  c_frame_accepted: cover property (
    (state_r == rbrm_pkg::ST_HEADER) && (hdr_index_r == rbrm_pkg::HDR_LAST_INDEX) && ce_i);
  c_page_linked: cover property (ce_i && link_needed && !link_abort);
  c_overflow_abort: cover property (ce_i && link_abort);
  c_frame_rejected: cover property (ce_i && (state_r == rbrm_pkg::ST_STORE) && frm_end_i && frame_reject);

endmodule
`default_nettype wire

// ---- hdl/rbrm_pkg.sv ----
// package: register map, field layout and types of the receive buffer ring manager
package rbrm_pkg;

  // ----------------------------------------------------------------
  // register indices on the plain register port
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_COMMAND = 4'h0;
  localparam logic [3:0] REG_RING_FIRST = 4'h1;
  localparam logic [3:0] REG_RING_LIMIT = 4'h2;
  localparam logic [3:0] REG_READ_PTR = 4'h3;
  localparam logic [3:0] REG_WRITE_PTR = 4'h4;
  localparam logic [3:0] REG_INT_STATUS = 4'h5;
  localparam logic [3:0] REG_RX_CONFIG = 4'h6;
  localparam logic [3:0] REG_TX_CONFIG = 4'h7;
  localparam logic [3:0] REG_MISSED = 4'h8;
  localparam logic [3:0] REG_RING_STATE = 4'h9;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CMD_HALT_BIT = 0;
  localparam int CMD_START_BIT = 1;
  localparam int CMD_TX_REQUEST_BIT = 2;
  localparam int INT_OVERWRITE_BIT = 4;
  localparam int RXC_ACCEPT_ERR_BIT = 0;
  localparam int RXC_ACCEPT_RUNT_BIT = 1;
  localparam int TXC_LOOP_LO_BIT = 1;
  localparam int TXC_LOOP_HI_BIT = 2;
  localparam int RST_FULL_BIT = 0;
  localparam int RST_EMPTY_BIT = 1;
  localparam int RST_BUSY_BIT = 2;

  // ----------------------------------------------------------------
  // reset values and fixed figures
  // ----------------------------------------------------------------
  localparam logic [7:0] COMMAND_RESET = 8'h21;
  localparam logic [7:0] PAGE_RESET = 8'h01;
  localparam logic [7:0] LIMIT_RESET = 8'h02;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] HEADER_BYTES = 8'h04;
  localparam logic [7:0] PAGE_LAST_OFFSET = 8'hff;
  localparam logic [1:0] HDR_LAST_INDEX = 2'h3;
  localparam logic [1:0] HDR_STATUS = 2'h0;
  localparam logic [1:0] HDR_NEXT_PAGE = 2'h1;
  localparam logic [1:0] HDR_COUNT_LO = 2'h2;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  localparam logic [7:0] MISSED_ONE = 8'h01;
  localparam logic [7:0] MISSED_MAX = 8'hff;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_STORE,
    ST_DROP,
    ST_HEADER
  } rbrm_state_type;

  // end-of-frame verdict from the receive front end
  typedef struct packed {
    logic runt;
    logic crc_err;
    logic align_err;
    logic [7:0] status;
  } rbrm_frame_end_type;

  // one byte write into local buffer memory
  typedef struct packed {
    logic we;
    logic [15:0] addr;
    logic [7:0] data;
  } rbrm_mem_wr_type;

endpackage

// ---- hdl/rbrm_page_link.sv ----
// page link calculator: next ring page with stop-to-start wrap and read pointer check
`timescale 1ns/1ns
`default_nettype none

module rbrm_page_link (
  // page in use and ring bounds
  input wire logic [7:0] page_i,
  input wire logic [7:0] first_page_i,
  input wire logic [7:0] limit_page_i,
  input wire logic [7:0] read_page_i,
  // linked page and its collision with unread data
  output logic [7:0] next_page_o,
  output logic hits_read_o
);

  logic [7:0] plus_one;

  // wrap first, then test the wrapped page against the read pointer
  always_comb begin
    plus_one = page_i + 8'h01;
    if (plus_one == limit_page_i) begin
      next_page_o = first_page_i;
    end else begin
      next_page_o = plus_one;
    end
    hits_read_o = (next_page_o == read_page_i);
  end

endmodule
`default_nettype wire

// ---- tb/rbrm_mem_model.sv ----
// local buffer memory model: stores byte writes, reads back and counts writes
`timescale 1ns/1ns
`default_nettype none

module rbrm_mem_model (
  // clock and write port
  input wire logic core_clk_i,
  input wire rbrm_pkg::rbrm_mem_wr_type mem_wr_i,
  // read-back port for the bench
  input wire logic [15:0] rd_addr_i,
  output logic [7:0] rd_data_o,
  output logic [31:0] wr_count_o
);
  logic [7:0] mem_r [0:65535];

  // unwritten bytes stay unknown, so a missing write can never pass for a match
  initial wr_count_o = 32'h0;
  always @(posedge core_clk_i) begin
    if (mem_wr_i.we === 1'b1) begin
      mem_r[mem_wr_i.addr] <= mem_wr_i.data;
      wr_count_o <= wr_count_o + 32'h1;
    end
  end
  assign rd_data_o = mem_r[rd_addr_i];
endmodule

`default_nettype wire

// ---- tb/rbrm_top_test.sv ----
// self-checking bench of the receive buffer ring manager
`timescale 1ns/1ns
`default_nettype none

module rbrm_top_test;
  logic core_clk_i, rst_n_i, ce_i, reg_wr_i, reg_rd_i, frm_start_i, frm_byte_valid_i, frm_end_i, warn, resend;
  logic [3:0] reg_addr_i;
  logic [7:0] reg_wdata_i, rdata, frm_byte_i, v, stat;
  logic [15:0] rd_addr;
  logic [7:0] rd_data;
  logic [31:0] wcnt, c, seed;
  rbrm_pkg::rbrm_frame_end_type frm_verdict_i;
  rbrm_pkg::rbrm_mem_wr_type mem_wr;
  logic [7:0] exp_b [0:1023];
  logic [7:0] rst_tab [0:9];
  int miscompares, n_compared, len, first, lim;

  rbrm_top dut_u (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(rdata),
    .frm_start_i(frm_start_i), .frm_byte_valid_i(frm_byte_valid_i), .frm_byte_i(frm_byte_i),
    .frm_end_i(frm_end_i), .frm_verdict_i(frm_verdict_i), .mem_wr_o(mem_wr), .ring_overwrite_warning_o(warn));
  rbrm_mem_model mem_u (.core_clk_i(core_clk_i), .mem_wr_i(mem_wr), .rd_addr_i(rd_addr), .rd_data_o(rd_data),
    .wr_count_o(wcnt));

  // clock: 50 ns period
  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end

  function automatic logic [31:0] lfsr_step(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // ring wrap as the host sees it: a page at the limit folds back to the first page
  function automatic int wrap(input int p);
    return (p >= lim) ? p - lim + first : p;
  endfunction

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk_i) {reg_addr_i, reg_wdata_i, reg_wr_i} <= {a, d, 1'b1};
    @(posedge core_clk_i) reg_wr_i <= 1'b0;
  endtask

  // read data stand only in the cycle after the read edge
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk_i) {reg_addr_i, reg_rd_i} <= {a, 1'b1};
    @(posedge core_clk_i) reg_rd_i <= 1'b0;
    @(negedge core_clk_i) d = rdata;
  endtask

  // one frame: start, random bytes back to back, end with verdict, then header time
  task automatic send(input int n, input logic [2:0] err);
    seed = lfsr_step(seed);
    stat = seed[15:8];
    @(posedge core_clk_i) frm_start_i <= 1'b1;
    for (int i = 0; i < n; i++) begin
      seed = lfsr_step(seed);
      exp_b[i] = seed[7:0];
      @(posedge core_clk_i) {frm_start_i, frm_byte_valid_i, frm_byte_i} <= {2'b01, seed[7:0]};
    end
    @(posedge core_clk_i) {frm_start_i, frm_byte_valid_i, frm_end_i, frm_verdict_i} <= {3'b001, err, stat};
    @(posedge core_clk_i) frm_end_i <= 1'b0;
    repeat (8) @(posedge core_clk_i);
  endtask

  // data from offset 4 on consecutive pages, then header and new write pointer
  task automatic check_frame(input int sp, input int n);
    int nxt;
    nxt = wrap(sp + (3 + n) / 256 + 1);
    for (int i = 0; i < n; i++) begin
      rd_addr = {8'(wrap(sp + (4 + i) / 256)), 8'(4 + i)};
      #1 check("stored byte", 16'(rd_data), 16'(exp_b[i]));
    end
    rd_addr = {8'(sp), 8'h00};
    #1 check("header status", 16'(rd_data), 16'(stat));
    rd_addr = {8'(sp), 8'h01};
    #1 check("header next page", 16'(rd_data), 16'(nxt));
    rd_addr = {8'(sp), 8'h02};
    #1 check("header count", 16'(rd_data), 16'(8'(n)));
    rd_addr = {8'(sp), 8'h03};
    #1 check("header count high", 16'(rd_data), 16'(8'(n >> 8)));
    rd_reg(rbrm_pkg::REG_WRITE_PTR, v);
    check("write pointer", 16'(v), 16'(nxt));
  endtask

  task automatic report_and_stop;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // watchdog: the halt wait alone is 32000 cycles
  initial begin
    repeat (80000) @(posedge core_clk_i);
    miscompares++;
    report_and_stop;
  end

  initial begin
    {rst_n_i, reg_wr_i, reg_rd_i, frm_start_i, frm_byte_valid_i, frm_end_i} = 6'h0;
    {reg_addr_i, reg_wdata_i, frm_byte_i, frm_verdict_i, rd_addr} = '0;
    ce_i = 1'b1;
    seed = 32'hee9e;
    rst_tab = '{rbrm_pkg::COMMAND_RESET, rbrm_pkg::PAGE_RESET, rbrm_pkg::LIMIT_RESET, rbrm_pkg::PAGE_RESET,
      rbrm_pkg::PAGE_RESET, 8'h00, 8'h00, 8'h00, 8'h00, 8'(1 << rbrm_pkg::RST_EMPTY_BIT)};
    repeat (12) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    for (int a = 0; a < 10; a++) begin
      rd_reg(4'(a), v);
      check("reset value", 16'(v), 16'(rst_tab[a]));
    end
    rd_reg(4'hf, v);
    check("unmapped read", 16'(v), 16'h0);
    // enable sequence: halt, config, loopback, ring bounds, clear status, page 1, start
    wr_reg(rbrm_pkg::REG_COMMAND, 8'h21);
    wr_reg(rbrm_pkg::REG_RX_CONFIG, 8'h00);
    wr_reg(rbrm_pkg::REG_TX_CONFIG, 8'h02);
    wr_reg(rbrm_pkg::REG_RING_FIRST, 8'h04);
    wr_reg(rbrm_pkg::REG_RING_LIMIT, 8'h08);
    wr_reg(rbrm_pkg::REG_READ_PTR, 8'h04);
    wr_reg(rbrm_pkg::REG_INT_STATUS, 8'hff);
    wr_reg(rbrm_pkg::REG_COMMAND, 8'h61);
    wr_reg(rbrm_pkg::REG_WRITE_PTR, 8'h04);
    wr_reg(rbrm_pkg::REG_COMMAND, 8'h22);
    first = 4;
    lim = 8;
    c = wcnt;
    send(40, 3'b000);
    check("loopback writes", 16'(wcnt - c), 16'h0);
    wr_reg(rbrm_pkg::REG_TX_CONFIG, 8'h00);
    len = 257 + int'(seed[6:0]);
    send(len, 3'b000);
    check_frame(4, len);
    // three-page frame: the link out of page 7 meets the limit and wraps to page 4
    wr_reg(rbrm_pkg::REG_READ_PTR, 8'h06);
    len = 509 + int'(seed[6:0]);
    send(len, 3'b000);
    check_frame(6, len);
    // runt, crc and alignment errors each give their pages back
    for (int k = 0; k < 3; k++) begin
      send(20, 3'b100 >> k);
      rd_reg(rbrm_pkg::REG_WRITE_PTR, v);
      check("rejected write pointer", 16'(v), 16'h5);
    end
    // accepted crc error moves the write pointer onto the read pointer: ring full
    wr_reg(rbrm_pkg::REG_RX_CONFIG, 8'h01);
    send(20, 3'b010);
    check_frame(5, 20);
    rd_reg(rbrm_pkg::REG_RING_STATE, v);
    check("ring full", 16'(v), 16'(1 << rbrm_pkg::RST_FULL_BIT));
    wr_reg(rbrm_pkg::REG_RX_CONFIG, 8'h00);
    // overflow: a start into the full ring is dropped whole
    c = wcnt;
    send(300, 3'b000);
    check("full ring writes", 16'(wcnt - c), 16'h0);
    rd_reg(rbrm_pkg::REG_WRITE_PTR, v);
    check("overflow write pointer", 16'(v), 16'h6);
    check("warning output", 16'(warn), 16'h1);
    rd_reg(rbrm_pkg::REG_MISSED, v);
    check("missed tally", 16'(v), 16'h1);
    // full recovery: save transmit request, halt and wait out any frame in flight
    rd_reg(rbrm_pkg::REG_COMMAND, v);
    check("saved command", 16'(v), 16'h22);
    // no transmit flags live in this block, so sent and error flags read as clear
    resend = v[rbrm_pkg::CMD_TX_REQUEST_BIT];
    wr_reg(rbrm_pkg::REG_COMMAND, 8'h21);
    repeat (32000) @(posedge core_clk_i);
    // remote byte counts live outside this block, nothing to clear here
    c = wcnt;
    send(20, 3'b000);
    rd_reg(rbrm_pkg::REG_MISSED, v);
    check("halted tally", 16'(v) + 16'(wcnt - c), 16'h1);
    wr_reg(rbrm_pkg::REG_TX_CONFIG, 8'h04);
    wr_reg(rbrm_pkg::REG_COMMAND, 8'h22);
    send(20, 3'b000);
    check("loopback writes", 16'(wcnt - c), 16'h0);
    wr_reg(rbrm_pkg::REG_READ_PTR, 8'h07);
    wr_reg(rbrm_pkg::REG_INT_STATUS, 8'h10);
    rd_reg(rbrm_pkg::REG_INT_STATUS, v);
    check("warning cleared", 16'(v[rbrm_pkg::INT_OVERWRITE_BIT]), 16'h0);
    check("warning output cleared", 16'(warn), 16'h0);
    wr_reg(rbrm_pkg::REG_TX_CONFIG, 8'h00);
    if (resend) begin
      wr_reg(rbrm_pkg::REG_COMMAND, 8'h26);
    end
    // next page of this frame meets the read pointer, so the ring reads full
    len = 20 + int'(seed[6:0]);
    send(len, 3'b000);
    check_frame(6, len);
    rd_reg(rbrm_pkg::REG_RING_STATE, v);
    check("ring full again", 16'(v), 16'(1 << rbrm_pkg::RST_FULL_BIT));
    // link abort: the wrap out of page 7 lands on the read pointer at page 4
    wr_reg(rbrm_pkg::REG_READ_PTR, 8'h04);
    c = wcnt;
    send(300, 3'b000);
    check("overflow writes", 16'(wcnt - c), 16'h00fc);
    rd_reg(rbrm_pkg::REG_WRITE_PTR, v);
    check("abort write pointer", 16'(v), 16'h7);
    rd_reg(rbrm_pkg::REG_MISSED, v);
    check("second missed tally", 16'(v), 16'h2);
    report_and_stop;
  end
endmodule

`default_nettype wire
